// File: verilog/pfl_pkg.sv
package pfl_pkg;

  // Register pointer values on the serial control port
  localparam logic [7:0] OFS_DEN_LOW   = 8'h20;
  localparam logic [7:0] OFS_SD_CTL    = 8'h21;
  localparam logic [7:0] OFS_LOOP_1ST  = 8'h22;
  localparam logic [7:0] OFS_LOOP_2ND  = 8'h23;
  localparam logic [7:0] OFS_R2_CODE   = 8'h24;

  // Field positions inside the control bytes
  localparam int SD_DITHER_LSB  = 2;
  localparam int SD_ORDER_LSB   = 0;
  localparam int L1_SPARE_LSB   = 6;
  localparam int L1_DOUBLER_BIT = 5;
  localparam int L1_PUMP_LSB    = 0;
  localparam int L2_PHASE_LSB   = 4;
  localparam int L2_C3_BIT      = 2;
  localparam int L2_FIXED_LSB   = 0;

  // Reset values
  localparam logic [7:0] DEN_LOW_RST = 8'hFF;
  localparam logic [1:0] DITHER_RST  = 2'h0;
  localparam logic [1:0] ORDER_RST   = 2'h3;
  localparam logic [1:0] L1_SPARE_RST = 2'h0;
  localparam logic       DOUBLER_RST = 1'h1;
  localparam logic [3:0] PUMP_RST    = 4'h4;
  localparam logic [2:0] PHASE_RST   = 3'h2;
  localparam logic       C3_RST      = 1'h1;
  localparam logic [1:0] L2_FIXED_VAL = 2'h3;
  localparam logic [7:0] R2_RST      = 8'h24;

  // Field encodings
  localparam logic [1:0] DITHER_WEAK = 2'h0;
  localparam logic [1:0] DITHER_OFF  = 2'h3;
  localparam logic [1:0] ORDER_INT   = 2'h0;
  localparam logic [1:0] ORDER_THIRD = 2'h3;
  localparam logic [3:0] PUMP_1P6MA  = 4'h4;
  localparam logic [3:0] PUMP_6P4MA  = 4'h8;

  // Denominator assembly
  localparam int DEN_WIDTH = 22;

  // Serial slave states, one-hot
  typedef enum logic [8:0] {
    PFL_IDLE      = 9'h001,
    PFL_ADDR      = 9'h002,
    PFL_ADDR_ACK  = 9'h004,
    PFL_PTR       = 9'h008,
    PFL_PTR_ACK   = 9'h010,
    PFL_WDATA     = 9'h020,
    PFL_WDATA_ACK = 9'h040,
    PFL_RDATA     = 9'h080,
    PFL_RDATA_ACK = 9'h100
  } pfl_state_t;

endpackage

// File: verilog/pfl_reg_bank.sv
`timescale 1ns/1ps
module pfl_reg_bank (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Write strobe with data
  input  wire logic       wr_stb,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // Read port
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rd_data,
  // Analog settings
  output logic      [7:0] frac_denominator_low,
  output logic      [1:0] dither_select,
  output logic      [1:0] sd_order,
  output logic            doubler_on,
  output logic      [3:0] pump_current_code,
  output logic      [2:0] pump_phase_delay,
  output logic            third_cap_on,
  output logic      [7:0] filter_r2_code
);

  typedef struct packed {
    logic [7:0] den_low;  // Denominator bits 7:0
    logic [1:0] dither;   // Dither mode
    logic [1:0] order;    // Modulator order
    logic [1:0] l1_spare; // Spare bits, stored and read back
    logic       doubler;  // Reference doubler enable
    logic [3:0] pump;     // Charge pump current code
    logic [2:0] phase;    // Charge pump phase delay
    logic       c3;       // Third capacitor enable
    logic [7:0] r2;       // Loop filter R2 code
  } pfl_bank_t;

  pfl_bank_t r;       // Registered state
  pfl_bank_t next_r;  // Next state

  // Byte view of a register; unmapped pointers and unused bits other than the fixed pair of 0x23 read zero
  function automatic logic [7:0] pfl_byte(input logic [7:0] a, input pfl_bank_t s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      pfl_pkg::OFS_DEN_LOW:  v = s.den_low;
      pfl_pkg::OFS_SD_CTL: begin
        v[pfl_pkg::SD_DITHER_LSB +: 2] = s.dither;
        v[pfl_pkg::SD_ORDER_LSB +: 2]  = s.order;
      end
      pfl_pkg::OFS_LOOP_1ST: begin
        v[pfl_pkg::L1_SPARE_LSB +: 2] = s.l1_spare;
        v[pfl_pkg::L1_DOUBLER_BIT]    = s.doubler;
        v[pfl_pkg::L1_PUMP_LSB +: 4]  = s.pump;
      end
      pfl_pkg::OFS_LOOP_2ND: begin
        v[pfl_pkg::L2_PHASE_LSB +: 3] = s.phase;
        v[pfl_pkg::L2_C3_BIT]         = s.c3;
        // Fixed spare pair always reads its default
        v[pfl_pkg::L2_FIXED_LSB +: 2] = pfl_pkg::L2_FIXED_VAL;
      end
      pfl_pkg::OFS_R2_CODE:  v = s.r2;
      default:               v = 8'h00;
    endcase
    return v;
  endfunction

  // Write decode; reserved bits without storage drop the written value
  always_comb begin
    next_r = r;
    if (wr_stb) begin
      case (wr_addr)
        pfl_pkg::OFS_DEN_LOW:  next_r.den_low = wr_data;
        pfl_pkg::OFS_SD_CTL: begin
          next_r.dither = wr_data[pfl_pkg::SD_DITHER_LSB +: 2];
          next_r.order  = wr_data[pfl_pkg::SD_ORDER_LSB +: 2];
        end
        pfl_pkg::OFS_LOOP_1ST: begin
          next_r.l1_spare = wr_data[pfl_pkg::L1_SPARE_LSB +: 2];
          next_r.doubler  = wr_data[pfl_pkg::L1_DOUBLER_BIT];
          // Stored as written; keeping to the two legal codes is up to the host
          next_r.pump     = wr_data[pfl_pkg::L1_PUMP_LSB +: 4];
        end
        pfl_pkg::OFS_LOOP_2ND: begin
          next_r.phase = wr_data[pfl_pkg::L2_PHASE_LSB +: 3];
          next_r.c3    = wr_data[pfl_pkg::L2_C3_BIT];
        end
        pfl_pkg::OFS_R2_CODE:  next_r.r2 = wr_data;
        default:               next_r = r;
      endcase
    end
  end

  // State register with listed defaults
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r.den_low  <= pfl_pkg::DEN_LOW_RST;
      r.dither   <= pfl_pkg::DITHER_RST;
      r.order    <= pfl_pkg::ORDER_RST;
      r.l1_spare <= pfl_pkg::L1_SPARE_RST;
      r.doubler  <= pfl_pkg::DOUBLER_RST;
      r.pump     <= pfl_pkg::PUMP_RST;
      r.phase    <= pfl_pkg::PHASE_RST;
      r.c3       <= pfl_pkg::C3_RST;
      r.r2       <= pfl_pkg::R2_RST;
    end else begin
      r <= next_r;
    end
  end

  // Setting outputs straight from flops; rd_data decoded from them by pointer
  assign rd_data              = pfl_byte(rd_addr, r);
  assign frac_denominator_low = r.den_low;
  assign dither_select        = r.dither;
  assign sd_order             = r.order;
  assign doubler_on           = r.doubler;
  assign pump_current_code    = r.pump;
  assign pump_phase_delay     = r.phase;
  assign third_cap_on         = r.c3;
  assign filter_r2_code       = r.r2;

endmodule // pfl_reg_bank

// File: verilog/pfl_config_regs.sv
`timescale 1ns/1ps
module pfl_config_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h5A  // Bus address, arbitrary value
) (
  // Clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            rst_n,
  // Two-wire control port, open drain data
  input  wire logic                            scl_in,
  input  wire logic                            sda_in,
  output logic                                 sda_out,
  output logic                                 sda_oe,
  // Upper denominator bytes held elsewhere
  input  wire logic [5:0]                      frac_den_upper,
  input  wire logic [7:0]                      frac_den_mid,
  // Analog settings
  output logic      [pfl_pkg::DEN_WIDTH-1:0]   frac_denominator,
  output logic      [1:0]                      dither_select,
  output logic      [1:0]                      sd_order,
  output logic                                 doubler_on,
  output logic      [3:0]                      pump_current_code,
  output logic      [2:0]                      pump_phase_delay,
  output logic                                 third_cap_on,
  output logic      [7:0]                      filter_r2_code
);

  typedef struct packed {
    pfl_pkg::pfl_state_t st;     // Transfer phase
    logic                scl_q;  // Last clock sample
    logic                sda_q;  // Last data sample
    logic [7:0]          shreg;  // Byte shifter
    logic [3:0]          bitcnt; // Bits in current byte
    logic [7:0]          ptr;    // Register pointer, auto increments
    logic                rw;     // Read transfer selected
    logic                oe;     // Pull data line low
    logic                wr_stb; // One-cycle write strobe
    logic [7:0]          wr_data;// Byte to write
  } pfl_slave_t;

  pfl_slave_t s;       // Registered state
  pfl_slave_t next_s;  // Next state
  logic [7:0] rd_data; // Byte at the pointer
  logic [7:0] den_low; // Low denominator byte
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;

  // Line events from the previous sample; inputs are clock synchronous
  assign scl_rise   = scl_in & ~s.scl_q;
  assign scl_fall   = ~scl_in & s.scl_q;
  assign start_cond = scl_in & s.scl_q & s.sda_q & ~sda_in;
  assign stop_cond  = scl_in & s.scl_q & ~s.sda_q & sda_in;

  // Serial slave: byte framing, acknowledge and pointer handling
  always_comb begin
    next_s        = s;
    next_s.scl_q  = scl_in;
    next_s.sda_q  = sda_in;
    next_s.wr_stb = 1'b0;
    if (start_cond) begin
      // Start or repeated start always restarts address phase
      next_s.st     = pfl_pkg::PFL_ADDR;
      next_s.bitcnt = 4'h0;
      next_s.oe     = 1'b0;
    end else if (stop_cond) begin
      next_s.st = pfl_pkg::PFL_IDLE;
      next_s.oe = 1'b0;
    end else if (scl_rise) begin
      case (s.st)
        pfl_pkg::PFL_ADDR, pfl_pkg::PFL_PTR, pfl_pkg::PFL_WDATA: begin
          next_s.shreg  = {s.shreg[6:0], sda_in};
          next_s.bitcnt = s.bitcnt + 4'h1;
        end
        pfl_pkg::PFL_RDATA_ACK: begin
          // Host not-acknowledge ends the read burst
          if (sda_in) begin
            next_s.st = pfl_pkg::PFL_IDLE;
          end
        end
        default: next_s = next_s;
      endcase
    end else if (scl_fall) begin
      case (s.st)
        pfl_pkg::PFL_ADDR: begin
          if (s.bitcnt == 4'h8) begin
            if (s.shreg[7:1] == DEV_ADDR) begin
              next_s.st = pfl_pkg::PFL_ADDR_ACK;
              next_s.rw = s.shreg[0];
              next_s.oe = 1'b1;
            end else begin
              // Other device addressed; wait for next start
              next_s.st = pfl_pkg::PFL_IDLE;
            end
          end
        end
        pfl_pkg::PFL_ADDR_ACK: begin
          next_s.bitcnt = 4'h0;
          if (s.rw) begin
            // First read bit goes out right after our acknowledge
            next_s.st    = pfl_pkg::PFL_RDATA;
            next_s.shreg = rd_data;
            next_s.oe    = ~rd_data[7];
          end else begin
            next_s.st = pfl_pkg::PFL_PTR;
            next_s.oe = 1'b0;
          end
        end
        pfl_pkg::PFL_PTR: begin
          if (s.bitcnt == 4'h8) begin
            next_s.ptr = s.shreg;
            next_s.st  = pfl_pkg::PFL_PTR_ACK;
            next_s.oe  = 1'b1;
          end
        end
        pfl_pkg::PFL_PTR_ACK: begin
          next_s.st     = pfl_pkg::PFL_WDATA;
          next_s.bitcnt = 4'h0;
          next_s.oe     = 1'b0;
        end
        pfl_pkg::PFL_WDATA: begin
          if (s.bitcnt == 4'h8) begin
            // Byte complete: commit to the bank and acknowledge
            next_s.wr_stb  = 1'b1;
            next_s.wr_data = s.shreg;
            next_s.st      = pfl_pkg::PFL_WDATA_ACK;
            next_s.oe      = 1'b1;
          end
        end
        pfl_pkg::PFL_WDATA_ACK: begin
          next_s.ptr    = s.ptr + 8'h01;
          next_s.st     = pfl_pkg::PFL_WDATA;
          next_s.bitcnt = 4'h0;
          next_s.oe     = 1'b0;
        end
        pfl_pkg::PFL_RDATA: begin
          if (s.bitcnt == 4'h7) begin
            // Release for the host acknowledge and move on
            next_s.st  = pfl_pkg::PFL_RDATA_ACK;
            next_s.oe  = 1'b0;
            next_s.ptr = s.ptr + 8'h01;
          end else begin
            next_s.shreg  = {s.shreg[6:0], 1'b0};
            next_s.bitcnt = s.bitcnt + 4'h1;
            next_s.oe     = ~s.shreg[6];
          end
        end
        pfl_pkg::PFL_RDATA_ACK: begin
          // Host acknowledged: next byte from the advanced pointer
          next_s.st     = pfl_pkg::PFL_RDATA;
          next_s.bitcnt = 4'h0;
          next_s.shreg  = rd_data;
          next_s.oe     = ~rd_data[7];
        end
        default: next_s = next_s;
      endcase
    end
  end

  // Slave state register; lines idle high
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s.st      <= pfl_pkg::PFL_IDLE;
      s.scl_q   <= 1'b1;
      s.sda_q   <= 1'b1;
      s.shreg   <= 8'h00;
      s.bitcnt  <= 4'h0;
      s.ptr     <= 8'h00;
      s.rw      <= 1'b0;
      s.oe      <= 1'b0;
      s.wr_stb  <= 1'b0;
      s.wr_data <= 8'h00;
    end else begin
      s <= next_s;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = s.oe;

  // Register bank; writes land one cycle after the byte completes
  pfl_reg_bank u_bank (
    .core_clk             (core_clk),
    .rst_n                (rst_n),
    .wr_stb               (s.wr_stb),
    .wr_addr              (s.ptr),
    .wr_data              (s.wr_data),
    .rd_addr              (s.ptr),
    .rd_data              (rd_data),
    .frac_denominator_low (den_low),
    .dither_select        (dither_select),
    .sd_order             (sd_order),
    .doubler_on           (doubler_on),
    .pump_current_code    (pump_current_code),
    .pump_phase_delay     (pump_phase_delay),
    .third_cap_on         (third_cap_on),
    .filter_r2_code       (filter_r2_code)
  );

  // Full denominator: upper, middle and low bytes
  assign frac_denominator = {frac_den_upper, frac_den_mid, den_low};

endmodule // pfl_config_regs

// File: dv/pfl_chk.sv
`timescale 1ns/1ps
module pfl_chk (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Serial port
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  // Denominator parts
  input wire logic [5:0]  frac_den_upper,
  input wire logic [7:0]  frac_den_mid,
  input wire logic [21:0] frac_denominator,
  // Settings
  input wire logic [1:0]  dither_select,
  input wire logic [1:0]  sd_order,
  input wire logic        doubler_on,
  input wire logic [3:0]  pump_current_code,
  input wire logic [2:0]  pump_phase_delay,
  input wire logic        third_cap_on,
  input wire logic [7:0]  filter_r2_code
);
  // All host-written settings together, so one check covers every field
  logic [28:0] cfg;
  assign cfg = {frac_denominator[7:0], dither_select, sd_order, doubler_on,
                pump_current_code, pump_phase_delay, third_cap_on, filter_r2_code};
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  chk_den_join: assert property (
    frac_denominator[21:8] == {frac_den_upper, frac_den_mid}) else $error("upper bytes lost");
  chk_den_reset: assert property (
    $rose(rst_n) |-> frac_denominator[7:0] == 8'hFF) else $error("low byte default");
  chk_sd_reset: assert property (
    $rose(rst_n) |-> dither_select == 2'h0 && sd_order == 2'h3) else $error("mash defaults");
  chk_loop_reset: assert property (
    $rose(rst_n) |-> {doubler_on, pump_current_code, pump_phase_delay, third_cap_on,
    filter_r2_code, sda_oe} == {1'b1, 4'h4, 3'h2, 1'b1, 8'h24, 1'b0}) else $error("loop defaults");
  // Settings move only inside an acknowledge, while the clock is low
  chk_write_ack: assert property (
    $changed(cfg) |-> sda_oe && !scl_in && !$past(scl_in)) else $error("setting moved off ack");
  // Data line moves one cycle after a sampled clock fall, never later
  chk_oe_timing: assert property (
    $changed(sda_oe) |-> !scl_in && !$past(scl_in) && $past(scl_in, 2)) else $error("oe timing");
  chk_oe_hold: assert property (
    $rose(sda_oe) |=> sda_oe [*3]) else $error("pull released early");
  chk_open_drain: assert property (
    sda_oe |-> sda_out == 1'b0) else $error("data driven high");
endmodule // pfl_chk

bind pfl_config_regs pfl_chk chk_u (
  .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .frac_den_upper(frac_den_upper), .frac_den_mid(frac_den_mid),
  .frac_denominator(frac_denominator), .dither_select(dither_select), .sd_order(sd_order),
  .doubler_on(doubler_on), .pump_current_code(pump_current_code),
  .pump_phase_delay(pump_phase_delay), .third_cap_on(third_cap_on),
  .filter_r2_code(filter_r2_code)
);

// File: dv/pfl_host.sv
`timescale 1ns/1ps
module pfl_host (
  // Clock
  input  wire logic core_clk,
  // Bus lines: clock driven, data pulled low or released
  input  wire logic sda_line,
  output logic      scl = 1'b1,
  output logic      sda_pull = 1'b0
);
  // Third of a bit in core clocks; keeps each clock phase above two cycles
  localparam int QTR = 3;
  // Change both lines just after an edge, then hold them a third of a bit
  task automatic step(input logic c, input logic p);
    scl = c;
    sda_pull = p;
    repeat (QTR) @(posedge core_clk);
    #1;
  endtask
  // Start or repeated start: data falls while the clock is high
  task automatic start_cond();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask
  // Stop: data rises while the clock is high
  task automatic stop_cond();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
  // Eight bits MSB first, then the acknowledge slot; a 1 releases the line
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    logic [8:0] word;
    logic [8:0] got;
    word = {tx, ack_in};
    for (int i = 8; i >= 0; i--) begin
      step(1'b0, !word[i]);
      step(1'b1, !word[i]);
      got[i] = sda_line;
      step(1'b0, !word[i]);
    end
    rx = got[8:1];
    ack_out = got[0];
  endtask
endmodule // pfl_host

// File: dv/pfl_config_regs_tb.sv
`timescale 1ns/1ps
module pfl_config_regs_tb;
  // Device bus address, arbitrary value
  localparam logic [6:0] DEV = 7'h3C;
  // Clock, reset, serial lines; data line has a pull-up
  logic        core_clk, rst_n, scl_in, host_pull, sda_out, sda_oe;
  wire logic   sda_in = !host_pull && !(sda_oe && !sda_out);
  // Denominator inputs and settings
  logic [21:0] frac_denominator;
  logic [7:0]  frac_den_mid, filter_r2_code;
  logic [5:0]  frac_den_upper;
  logic [3:0]  pump_current_code;
  logic [2:0]  pump_phase_delay;
  logic [1:0]  dither_select, sd_order;
  logic        doubler_on, third_cap_on;
  // Reference register images, counters, random state
  int          mdl [5];
  int          errors = 0;
  int          tests_run = 0;
  logic [15:0] seed = 16'hA797;

  pfl_config_regs #(.DEV_ADDR(DEV)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .frac_den_upper(frac_den_upper), .frac_den_mid(frac_den_mid),
    .frac_denominator(frac_denominator), .dither_select(dither_select), .sd_order(sd_order),
    .doubler_on(doubler_on), .pump_current_code(pump_current_code),
    .pump_phase_delay(pump_phase_delay), .third_cap_on(third_cap_on),
    .filter_r2_code(filter_r2_code));
  pfl_host host_u (.core_clk(core_clk), .sda_line(sda_in), .scl(scl_in), .sda_pull(host_pull));

  // 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Shift register step for random data
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Reference write keeps storable bits only; low pair of 0x23 reads 3
  function automatic void mdl_wr(input int p, input int d);
    int keep [5] = '{8'hFF, 8'h0F, 8'hEF, 8'h74, 8'hFF};
    if (p >= 8'h20 && p <= 8'h24) mdl[p - 8'h20] = (d & keep[p - 8'h20]) | (p == 8'h23 ? 3 : 0);
  endfunction
  // Unmapped pointers read as zero
  function automatic logic [7:0] mdl_rd(input int p);
    return (p >= 8'h20 && p <= 8'h24) ? 8'(mdl[p - 8'h20]) : 8'h00;
  endfunction
  // Count a comparison, report a miss
  task automatic note(input bit ok, input string what);
    tests_run++;
    if (!ok) begin
      errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic chk_ack(input logic got, input logic exp);
    note(got === exp, "acknowledge slot");
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    note(got === exp, $sformatf("read %h, expected %h", got, exp));
  endtask
  task automatic chk_outs();
    logic [42:0] exp;
    exp = {frac_den_upper, frac_den_mid, 8'(mdl[0]), 4'(mdl[1]), mdl[2][5], 4'(mdl[2]),
           3'(mdl[3] >> 4), mdl[3][2], 8'(mdl[4])};
    note({frac_denominator, dither_select, sd_order, doubler_on, pump_current_code,
          pump_phase_delay, third_cap_on, filter_r2_code} === exp, "settings outputs");
  endtask
  // Write burst; a foreign address must get no acknowledge and store nothing
  task automatic bus_write(input logic [6:0] adr, input logic [7:0] ptr, input logic [7:0] d [$]);
    logic [7:0] rx;
    logic       a;
    host_u.start_cond();
    host_u.xfer({adr, 1'b0}, 1'b1, rx, a);
    chk_ack(a, adr != DEV);
    host_u.xfer(ptr, 1'b1, rx, a);
    foreach (d[i]) begin
      host_u.xfer(d[i], 1'b1, rx, a);
      chk_ack(a, adr != DEV);
      if (adr == DEV) mdl_wr(ptr + i, d[i]);
    end
    host_u.stop_cond();
  endtask
  // Pointer, repeated start, n bytes with a NACK on the last
  task automatic bus_read(input logic [7:0] ptr, input int n);
    logic [7:0] rx;
    logic       a;
    host_u.start_cond();
    host_u.xfer({DEV, 1'b0}, 1'b1, rx, a);
    host_u.xfer(ptr, 1'b1, rx, a);
    host_u.start_cond();
    host_u.xfer({DEV, 1'b1}, 1'b1, rx, a);
    for (int i = 0; i < n; i++) begin
      host_u.xfer(8'hFF, i == n - 1, rx, a);
      chk_byte(rx, mdl_rd(ptr + i));
    end
    host_u.stop_cond();
  endtask
  // Verdict and end of run
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard: about 150 us of traffic is expected; 400 us (50000 clocks) keeps
  // a hung run inside the cycle budget while leaving ample margin
  initial begin
    #400000;
    errors++;
    conclude();
  end

  initial begin
    logic [7:0] q [$];
    rst_n = 1'b0;
    frac_den_upper = 6'h2A;
    frac_den_mid = 8'h5C;
    mdl = '{8'hFF, 8'h03, 8'h24, 8'h27, 8'h24};
    repeat (3) @(posedge core_clk);
    #1 rst_n = 1'b1;
    chk_outs();
    bus_read(8'h20, 5);
    // Every field code; reserved bit 4 of 0x22 and bits 7 and 3 of 0x23 written as ones, others as zeros; pump kept to its two codes
    for (int i = 0; i < 8; i++) begin
      q = {{4'h0, i[1:0], i[1:0]}, {i[1:0], i[2], 1'b1, (i[0] ? 4'h8 : 4'h4)},
           {1'b1, i[2:0], 1'b1, !i[0], 2'h0}};
      bus_write(DEV, 8'h21, q);
      chk_outs();
      bus_read(8'h21, 3);
    end
    // Random bursts over the bank and one unmapped byte past its end
    repeat (6) begin
      q.delete();
      for (int k = 0; k < 6; k++) begin
        seed = lfsr(seed);
        q.push_back(k == 2 ? {seed[7:4], (seed[0] ? 4'h8 : 4'h4)} : seed[15:8]);
      end
      frac_den_upper = seed[5:0];
      frac_den_mid = seed[13:6];
      bus_write(DEV, 8'h20, q);
      chk_outs();
      bus_read(8'h20, 6);
    end
    bus_write(DEV ^ 7'h01, 8'h24, {8'h00});
    chk_outs();
    // Reset in mid-run brings every default back
    rst_n = 1'b0;
    mdl = '{8'hFF, 8'h03, 8'h24, 8'h27, 8'h24};
    @(posedge core_clk);
    #1;
    chk_outs();
    rst_n = 1'b1;
    bus_read(8'h20, 5);
    conclude();
  end
endmodule // pfl_config_regs_tb
